// *** logic/etd_pkg.sv ***
// Purpose: Constants for the transmit descriptor control block
// Assumes: Descriptor word 0 layout, eight-word descriptor, 32-bit words
// Notes:   Used by the design only; bench and checker use literal values
`default_nettype none
package etd_pkg;
  localparam int unsigned DESC_WORDS      = 8;
  localparam int unsigned WORD_W          = 32;
  localparam int unsigned ADDR_W          = 32;
  localparam int unsigned OWN_BIT         = 31;
  localparam int unsigned IRQ_BIT         = 30;
  localparam int unsigned LAST_BIT        = 29;
  localparam int unsigned FIRST_BIT       = 28;
  localparam int unsigned CRC_SUP_BIT     = 27;
  localparam int unsigned PAD_SUP_BIT     = 26;
  localparam int unsigned TS_BIT          = 25;
  localparam int unsigned CRC_REP_BIT     = 24;
  localparam int unsigned CSUM_HI         = 23;
  localparam int unsigned CSUM_LO         = 22;
  localparam int unsigned EOR_BIT         = 21;
  localparam int unsigned CHAIN_BIT       = 20;
  localparam int unsigned ERR_SUM_BIT     = 15;
  localparam int unsigned BS2_HI          = 28;
  localparam int unsigned BS2_LO          = 16;
  localparam int unsigned BS1_HI          = 12;
  localparam int unsigned BS1_LO          = 0;
  localparam logic [15:0] MIN_FRAME_BYTES = 16'd64;
  localparam logic [31:0] WORD_BYTES      = 32'h0000_0004;
  localparam logic [31:0] DESC_BYTES      = 32'h0000_0020;
  localparam logic [2:0]  WORD0_IDX       = 3'h0;
  localparam logic [2:0]  WORD1_IDX       = 3'h1;
  localparam logic [2:0]  WORD3_IDX       = 3'h3;
  localparam logic [2:0]  LAST_WORD_IDX   = 3'h7;
  localparam logic [1:0]  CSUM_NONE       = 2'h0;
  localparam logic [1:0]  CSUM_IP_HDR     = 2'h1;
  localparam logic [1:0]  CSUM_NO_PSEUDO  = 2'h2;
  localparam logic [1:0]  CSUM_FULL       = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_CHECK, ST_SEND, ST_WRBACK, ST_NEXT
  } state_t;
endpackage : etd_pkg
`default_nettype wire

// *** logic/etd_tx_desc_ctrl.sv ***
// Purpose: Fetches and interprets transmit descriptors, hands frames to the MAC
// Assumes: Memory read/write port answers each request with a one-cycle ack
// Notes:   Word 0 control bits decoded, write-back of word 0 on completion
// How it works
// [R1] A descriptor is eight consecutive words, fetched as one unit.
// [R2] Word 0 bit 31 set means DMA owns descriptor; clear means host owns.
// [R3] DMA clears ownership after the frame is sent or buffers emptied.
// [R4] Host sets first descriptor ownership last, after later descriptors.
// [R5] Completion request on last segment pulses transmit interrupt status after send.
// [R6] Bit 29 marks last segment; host gives a non-zero buffer size.
// [R7] Bit 28 marks first segment; per-frame options latched only there.
// [R8] CRC suppress on first segment sends frame without appended CRC.
// [R9] Pad suppress clear pads frames under 64 bytes; set sends unpadded.
// [R10] Whenever padding applies, CRC is appended regardless of suppress.
// [R11] Timestamp request on first segment captures a timestamp for frame.
// [R12] CRC replace with CRC suppress overwrites last four bytes with new CRC.
// [R13] Host supplies four CRC bytes in buffer when asking for replacement.
// [R14] Checksum select 00 none, 01 header, 10 no pseudo, 11 full.
// [R15] End-of-ring returns to list base address for the next descriptor.
// [R16] Chain flag uses second address as next pointer, ignores size two.
// [R17] End-of-ring wins over chained next-descriptor addressing.
// [R18] Host should always set the chain flag in transmit descriptors.
// [R19] Error summary written back as OR of the write-back error flags.
// [R20] A descriptor owned by host stops advance until ownership returns.
// [R21] Multi-descriptor frames go out in order, first through last, unmixed.
`default_nettype none
module etd_tx_desc_ctrl (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Control
  input  wire logic        start,
  input  wire logic [31:0] list_base,
  input  wire logic        poll,
  // Memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // MAC transaction layer handoff
  output logic             seg_valid,
  output logic [31:0]      seg_buf1_addr,
  output logic [12:0]      seg_buf1_size,
  output logic [31:0]      seg_buf2_addr,
  output logic [12:0]      seg_buf2_size,
  output logic             seg_first,
  output logic             seg_last,
  output logic             frm_append_crc,
  output logic             frm_pad_short,
  output logic             frm_replace_crc,
  output logic             frm_timestamp,
  output logic [1:0]       frm_csum_mode,
  input  wire logic        seg_done,
  input  wire logic [15:0] seg_err_flags,
  // Status
  output logic             tx_irq_pulse,
  output logic             suspended,
  output logic             tx_error_summary
);

  typedef struct packed {
    etd_pkg::state_t state;
    logic [2:0]      widx;
    logic [31:0]     desc_addr;
    logic [31:0]     w0;
    logic [31:0]     w1;
    logic [31:0]     w2;
    logic [31:0]     w3;
    logic            in_frame;
    logic            mem_req;
    logic            mem_we;
    logic [31:0]     mem_addr;
    logic [31:0]     mem_wdata;
    logic            seg_valid;
    logic            append_crc;
    logic            pad_short;
    logic            replace_crc;
    logic            timestamp;
    logic [1:0]      csum_mode;
    logic            irq;
    logic            suspended;
    logic            err_sum;
    logic [12:0]     buf2_size;
  } etd_state_t;

  etd_state_t s_q, s_d;

  // Next descriptor address from word 0 and word 3
  function automatic logic [31:0] next_addr(input logic [31:0] w0, input logic [31:0] w3,
                                            input logic [31:0] cur, input logic [31:0] base);
    if (w0[etd_pkg::EOR_BIT])
      next_addr = base;                                   // [R15] [R17]
    else if (w0[etd_pkg::CHAIN_BIT])
      next_addr = w3;                                     // [R16]
    else
      next_addr = cur + etd_pkg::DESC_BYTES;              // [R1]
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    case (s_q.state)
      etd_pkg::ST_IDLE: begin
        if (start) begin
          s_d.desc_addr = list_base;
          s_d.in_frame  = 1'b0;
          s_d.suspended = 1'b0;
          s_d.widx      = etd_pkg::WORD0_IDX;
          s_d.mem_req   = 1'b1;
          s_d.mem_we    = 1'b0;
          s_d.mem_addr  = list_base;
          s_d.state     = etd_pkg::ST_FETCH;
        end
      end
      etd_pkg::ST_FETCH: begin
        if (mem_ack) begin
          // All eight words read unless word 0 is host-owned; first four retained
          case (s_q.widx)                                 // [R1]
            3'h0:    s_d.w0 = mem_rdata;
            3'h1:    s_d.w1 = mem_rdata;
            3'h2:    s_d.w2 = mem_rdata;
            3'h3:    s_d.w3 = mem_rdata;
            default: ;
          endcase
          if (s_q.widx == etd_pkg::WORD0_IDX && !mem_rdata[etd_pkg::OWN_BIT]) begin
            s_d.mem_req   = 1'b0;                         // [R2] [R20]
            s_d.suspended = 1'b1;
            s_d.state     = etd_pkg::ST_CHECK;
          end else if (s_q.widx == etd_pkg::LAST_WORD_IDX) begin
            s_d.mem_req = 1'b0;
            s_d.state   = etd_pkg::ST_CHECK;
          end else begin
            s_d.widx     = s_q.widx + 3'h1;
            s_d.mem_addr = s_q.mem_addr + etd_pkg::WORD_BYTES;
          end
        end
      end
      etd_pkg::ST_CHECK: begin
        if (s_q.suspended) begin
          // Host owns it: wait for a poll, then refetch
          if (poll) begin                                 // [R20]
            s_d.suspended = 1'b0;
            s_d.widx      = etd_pkg::WORD0_IDX;
            s_d.mem_req   = 1'b1;
            s_d.mem_addr  = s_q.desc_addr;
            s_d.state     = etd_pkg::ST_FETCH;
          end
        end else begin
          if (s_q.w0[etd_pkg::FIRST_BIT]) begin           // [R7] [R21]
            s_d.in_frame    = 1'b1;
            s_d.pad_short   = !s_q.w0[etd_pkg::PAD_SUP_BIT];                    // [R9]
            s_d.append_crc  = !s_q.w0[etd_pkg::CRC_SUP_BIT]
                              || !s_q.w0[etd_pkg::PAD_SUP_BIT];                 // [R8] [R10]
            s_d.replace_crc = s_q.w0[etd_pkg::CRC_REP_BIT]
                              && s_q.w0[etd_pkg::CRC_SUP_BIT];                  // [R12]
            s_d.timestamp   = s_q.w0[etd_pkg::TS_BIT];                          // [R11]
            s_d.csum_mode   = s_q.w0[etd_pkg::CSUM_HI:etd_pkg::CSUM_LO];        // [R14]
            s_d.err_sum     = 1'b0;
          end
          // Second size ignored when chained
          s_d.buf2_size = s_q.w0[etd_pkg::CHAIN_BIT] ? 13'h0000
                          : s_q.w1[etd_pkg::BS2_HI:etd_pkg::BS2_LO];                // [R16]
          s_d.seg_valid = 1'b1;
          s_d.state     = etd_pkg::ST_SEND;
        end
      end
      etd_pkg::ST_SEND: begin
        if (seg_done) begin
          s_d.seg_valid = 1'b0;
          s_d.err_sum   = s_q.err_sum | (|seg_err_flags);                        // [R19]
          s_d.mem_req   = 1'b1;
          s_d.mem_we    = 1'b1;
          s_d.mem_addr  = s_q.desc_addr;
          s_d.mem_wdata = {1'b0, s_q.w0[30:16], s_q.err_sum | (|seg_err_flags),
                           s_q.w0[14:0]};                 // [R3] [R19]
          s_d.state     = etd_pkg::ST_WRBACK;
        end
      end
      etd_pkg::ST_WRBACK: begin
        if (mem_ack) begin
          s_d.mem_req = 1'b0;
          s_d.mem_we  = 1'b0;
          if (s_q.w0[etd_pkg::LAST_BIT]) begin
            s_d.in_frame = 1'b0;                          // [R21]
            s_d.irq      = s_q.w0[etd_pkg::IRQ_BIT];      // [R5]
          end
          s_d.state = etd_pkg::ST_NEXT;
        end
      end
      etd_pkg::ST_NEXT: begin
        s_d.desc_addr = next_addr(s_q.w0, s_q.w3, s_q.desc_addr, list_base);
        s_d.widx      = etd_pkg::WORD0_IDX;
        s_d.mem_req   = 1'b1;
        s_d.mem_addr  = next_addr(s_q.w0, s_q.w3, s_q.desc_addr, list_base);
        s_d.state     = etd_pkg::ST_FETCH;
      end
      default: s_d.state = etd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_req          = s_q.mem_req;
  assign mem_we           = s_q.mem_we;
  assign mem_addr         = s_q.mem_addr;
  assign mem_wdata        = s_q.mem_wdata;
  assign seg_valid        = s_q.seg_valid;
  assign seg_buf1_addr    = s_q.w2;
  assign seg_buf1_size    = s_q.w1[etd_pkg::BS1_HI:etd_pkg::BS1_LO];
  assign seg_buf2_addr    = s_q.w3;
  assign seg_buf2_size    = s_q.buf2_size;
  assign seg_first        = s_q.w0[etd_pkg::FIRST_BIT];
  assign seg_last         = s_q.w0[etd_pkg::LAST_BIT];                               // [R6]
  assign frm_append_crc   = s_q.append_crc;
  assign frm_pad_short    = s_q.pad_short;
  assign frm_replace_crc  = s_q.replace_crc;
  assign frm_timestamp    = s_q.timestamp;
  assign frm_csum_mode    = s_q.csum_mode;
  assign tx_irq_pulse     = s_q.irq;
  assign suspended        = s_q.suspended;
  assign tx_error_summary = s_q.err_sum;

endmodule // etd_tx_desc_ctrl
`default_nettype wire

// *** sim/etd_mem_model.sv ***
// Purpose: System memory holding descriptors written by the host
// Assumes: Word index from address bits 9:2
// Notes:   Ack after lat idle cycles; read data scrambled between acks
`default_nettype none
module etd_mem_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  lat,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:255];
  logic [1:0]  cnt;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt >= lat) begin
      mem_ack <= 1'b1;
      cnt <= 2'h0;
      mem_rdata <= mem[mem_addr[9:2]];
      if (mem_we)
        mem[mem_addr[9:2]] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
        cnt <= cnt + 2'h1;
    end
  end
endmodule // etd_mem_model
`default_nettype wire

// *** sim/etd_checker.sv ***
// Purpose: Port assertions for the descriptor control block
// Assumes: Descriptors 32-byte aligned
// Notes:   Bound from the bench top file
`default_nettype none
module etd_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Memory port
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_ack,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic [31:0] list_base,
  // Segment handoff and status
  input wire logic        seg_valid,
  input wire logic        seg_done,
  input wire logic        frm_pad_short,
  input wire logic        frm_append_crc,
  input wire logic        tx_irq_pulse,
  input wire logic        suspended
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_own; mem_req && mem_we |-> !mem_wdata[31]; endproperty
  a_own: assert property (p_own) else $error("owner kept");
  property p_wbk; seg_valid && seg_done |=> !seg_valid && mem_req && mem_we; endproperty
  a_wbk: assert property (p_wbk) else $error("no write-back");
  property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_step;
    mem_req && mem_ack && !mem_we && mem_addr[4:2] inside {[1:6]}
      |=> mem_req && mem_addr == $past(mem_addr) + 32'h4;
  endproperty
  a_step: assert property (p_step) else $error("word order");
  property p_pad; frm_pad_short |-> frm_append_crc; endproperty
  a_pad: assert property (p_pad) else $error("pad without crc");
  property p_irq; tx_irq_pulse |=> !tx_irq_pulse; endproperty
  a_irq: assert property (p_irq) else $error("irq too long");
  property p_eor;
    mem_req && mem_we && mem_ack && mem_wdata[21]
      |-> ##[1:6] mem_req && !mem_we && mem_addr == list_base;
  endproperty
  a_eor: assert property (p_eor) else $error("ring not wrapped");
  property p_sus; !(seg_valid && suspended); endproperty
  a_sus: assert property (p_sus) else $error("sent while held");
  property p_hst;
    mem_ack && !mem_we && mem_addr[4:2] == 3'h0 && !mem_rdata[31] |-> ##[1:60] suspended;
  endproperty
  a_hst: assert property (p_hst) else $error("host word used");
endmodule // etd_checker
`default_nettype wire

// *** sim/tb_eth_tx_descriptor_control.sv ***
// Purpose: Self-checking bench for the descriptor control block
// Assumes: Memory model as partner, MAC side driven here
// Notes:   Expected values from a small integer model
`default_nettype none
module tb_eth_tx_descriptor_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, rst = 1, start = 0, poll = 0, seg_done = 0;
  logic [31:0] list_base = 32'h100;
  logic [15:0] seg_err_flags = 16'h0;
  logic [1:0]  lat = 2'h0, frm_csum_mode;
  logic        mem_req, mem_we, mem_ack, seg_valid, seg_first, seg_last, frm_append_crc;
  logic        frm_pad_short, frm_replace_crc, frm_timestamp, tx_irq_pulse, suspended;
  logic        tx_error_summary;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, seg_buf1_addr, seg_buf2_addr;
  logic [12:0] seg_buf1_size, seg_buf2_size;
  logic [5:0]  opt;
  int          miscompares = 0, comparisons = 0, irqs = 0, acc = 0, i;
  etd_tx_desc_ctrl DUT (
    .mclk             (mclk),
    .rst              (rst),
    .start            (start),
    .list_base        (list_base),
    .poll             (poll),
    .mem_req          (mem_req),
    .mem_we           (mem_we),
    .mem_addr         (mem_addr),
    .mem_wdata        (mem_wdata),
    .mem_ack          (mem_ack),
    .mem_rdata        (mem_rdata),
    .seg_valid        (seg_valid),
    .seg_buf1_addr    (seg_buf1_addr),
    .seg_buf1_size    (seg_buf1_size),
    .seg_buf2_addr    (seg_buf2_addr),
    .seg_buf2_size    (seg_buf2_size),
    .seg_first        (seg_first),
    .seg_last         (seg_last),
    .frm_append_crc   (frm_append_crc),
    .frm_pad_short    (frm_pad_short),
    .frm_replace_crc  (frm_replace_crc),
    .frm_timestamp    (frm_timestamp),
    .frm_csum_mode    (frm_csum_mode),
    .seg_done         (seg_done),
    .seg_err_flags    (seg_err_flags),
    .tx_irq_pulse     (tx_irq_pulse),
    .suspended        (suspended),
    .tx_error_summary (tx_error_summary)
  );
  etd_mem_model mem_i (
    .mclk      (mclk),
    .rst       (rst),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .lat       (lat),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
  );
  initial forever #5 mclk = ~mclk;
  always @(negedge mclk) if (tx_irq_pulse === 1'b1) irqs++;
  task automatic chk(string n, logic [31:0] e, s);
    comparisons++;
    if (e !== s) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic put(int a, logic [31:0] w0, w3, w1);
    mem_i.mem[64+8*a] = w0;
    mem_i.mem[65+8*a] = w1 | 32'h1;
    mem_i.mem[66+8*a] = 32'hA000_0000 + a;
    mem_i.mem[67+8*a] = w3;
  endtask
  task automatic seg(int a, logic [31:0] nxt);
    logic [31:0] w0, w1;
    logic [15:0] ef;
    logic [5:0]  got;
    int n;
    w0 = mem_i.mem[64+8*a];
    w1 = mem_i.mem[65+8*a];
    lat = 2'($urandom);
    for (i = 0; i < 400 && seg_valid !== 1'b1; i++) @(negedge mclk);
    chk("valid", 1, seg_valid);
    if (w0[28]) begin
      opt = {!w0[27] | !w0[26], !w0[26], w0[24] & w0[27], w0[25], w0[23:22]};
      acc = 0;
    end
    got = {frm_append_crc, frm_pad_short, frm_replace_crc, frm_timestamp, frm_csum_mode};
    chk("options", opt, got);
    chk("marks", w0[29:28], {seg_last, seg_first});
    chk("size1", w1[12:0], seg_buf1_size);
    chk("size2", w0[20] ? 13'h0 : w1[28:16], seg_buf2_size);
    chk("buf1", 32'hA000_0000 + a, seg_buf1_addr);
    chk("buf2", mem_i.mem[67+8*a], seg_buf2_addr);
    ef = ($urandom % 2) ? 16'($urandom) : 16'h0;
    acc = acc | (ef != 0);
    n = irqs;
    seg_err_flags = ef;
    seg_done = 1'b1;
    @(negedge mclk);
    seg_done = 1'b0;
    for (i = 0; i < 400 && !(mem_req && !mem_we); i++) @(negedge mclk);
    chk("fetch", 1, mem_req && !mem_we);
    chk("word0", {1'b0, w0[30:16], acc[0], w0[14:0]}, mem_i.mem[64+8*a]);
    chk("irq", w0[30] & w0[29], irqs - n);
    chk("err", acc, tx_error_summary);
    chk("next", nxt, mem_addr);
  endtask
  initial begin
    i = $urandom(32'hF273);
    for (int k = 0; k < 4; k++)
      put(k, 32'hF000_0000 | ($urandom & 32'h0F00_0000) | (k << 22), 0, $urandom);
    put(5, 32'hE010_0000 | ($urandom & 32'h0FC0_0000), 32'h1E0, 32'h40);
    put(4, 32'h9000_0000 | ($urandom & 32'h0FC0_0000), 0, 32'h40);
    put(7, 32'hF030_0000, 32'h220, 32'h40);
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    for (int k = 0; k < 5; k++) seg(k, 32'h100 + 32 * (k + 1));
    seg(5, 32'h1E0);
    seg(7, 32'h100);
    repeat (60) @(negedge mclk);
    chk("suspended", 1, suspended);
    chk("held", 0, seg_valid);
    put(0, 32'hF020_0000, 0, 32'h40);
    poll = 1'b1;
    @(negedge mclk);
    poll = 1'b0;
    seg(0, 32'h100);
    report_and_stop;
  end
  initial begin
    #200us;
    miscompares++;
    report_and_stop;
  end
endmodule // tb_eth_tx_descriptor_control
bind etd_tx_desc_ctrl etd_checker u_chk (
  .mclk           (mclk),
  .rst            (rst),
  .mem_req        (mem_req),
  .mem_we         (mem_we),
  .mem_ack        (mem_ack),
  .mem_addr       (mem_addr),
  .mem_wdata      (mem_wdata),
  .mem_rdata      (mem_rdata),
  .list_base      (list_base),
  .seg_valid      (seg_valid),
  .seg_done       (seg_done),
  .frm_pad_short  (frm_pad_short),
  .frm_append_crc (frm_append_crc),
  .tx_irq_pulse   (tx_irq_pulse),
  .suspended      (suspended)
);
`default_nettype wire
